// [rtl/cs_decode_defines.vh]
//
// Function
// R1: each chip-select takes its block size from the three lowest bits of its base address register.
// R2: block size codes 000 to 111 give 2K, 8K, 16K, 64K, 128K, 256K, 512K and 1M, comparing ADDR[23:11] down to ADDR[23:20].
// R3: a base address is taken as aligned to its block, so base bits below the compared range are ignored.
// R4: only the address lines chosen by the block size are compared, never the whole 24-bit bus.
// R5: several chip-selects may match one address at once and each one that matches is asserted.
// R6: with several matching chip-selects the access ends on the earliest termination of any of them.
// R7: overlap follows jointly from the base address and block size of each base address register.
// R8: an asserted external size acknowledge terminates the cycle, cutting short the programmed wait states.
// R9: a low bus control strap at reset, or the pin assignment bit later, turns the acknowledge pins into general I/O.
// R10: the boot width strap sampled at reset makes the boot chip-select 16-bit when high and 8-bit when low.
// R11: base address register bits 15 to 3 hold address bits 23 to 11, masked by the block size.
// R12: each chip-select counts its option register wait states after a match and then terminates the cycle.
`ifndef CS_DECODE_DEFINES_VH
`define CS_DECODE_DEFINES_VH

// ----------------------------------------------------------------
// chip-select population and fields
// ----------------------------------------------------------------
`define CS_COUNT        12
`define CS_BLK_LSB      0
`define CS_BLK_MSB      2
`define CS_BASE_LSB     3
`define CS_BASE_MSB     15
`define CS_OPT_EN_BIT   15
`define CS_OPT_WAIT_LSB 0
`define CS_OPT_WAIT_MSB 3

// ----------------------------------------------------------------
// reset values (boot chip-select is index 0)
// ----------------------------------------------------------------
`define CS_BOOT_BASE_RST 16'h0007
`define CS_BOOT_OPT_RST  16'h800F
`define CS_BASE_RST      16'h0000
`define CS_OPT_RST       16'h0000

// ----------------------------------------------------------------
// register map: base at 8*i, option at 8*i+4, then config and hits
// ----------------------------------------------------------------
`define REG_IDX_MSB     6
`define REG_IDX_LSB     3
`define REG_SEL_BIT     2
`define REG_CFG_IDX     4'hC
`define CFG_GPIO_BIT    0
`define CFG_PORT16_BIT  1
`define CFG_ACTIVE_BIT  2
`define STRAP_DELAY     2'h2

`endif

// [rtl/cs_unit.v]
`timescale 1ns/1ns
`include "cs_decode_defines.vh"

module cs_unit (
   input  wire        core_clk,
   input  wire        nrst,
   input  wire [15:0] baseReg,
   input  wire [15:0] optionReg,
   input  wire [23:0] accAddr,
   input  wire        accStart,
   input  wire        accEnd,
   output reg         hit,
   output wire        termReq
);

   reg [3:0] waitCount;

   // ----------------------------------------------------------------
   // address match
   // ----------------------------------------------------------------
   // masked compare of address lines 23..11 against the base field
   function matchFn;
      input [15:0] base;
      input [23:0] addr;
      reg   [12:0] mask;
      begin
         case (base[`CS_BLK_MSB:`CS_BLK_LSB])               // [R1] [R2]
            3'h0:    mask = 13'h1FFF;
            3'h1:    mask = 13'h1FFC;
            3'h2:    mask = 13'h1FF8;
            3'h3:    mask = 13'h1FE0;
            3'h4:    mask = 13'h1FC0;
            3'h5:    mask = 13'h1F80;
            3'h6:    mask = 13'h1F00;
            default: mask = 13'h1E00;
         endcase
         // low base bits are masked off too [R3] [R4] [R11] [R7]
         matchFn = ((addr[23:11] & mask) ==
                    (base[`CS_BASE_MSB:`CS_BASE_LSB] & mask));
      end
   endfunction

   // ----------------------------------------------------------------
   // hit flag and wait-state counter
   // ----------------------------------------------------------------
   // match latched at cycle start, counter runs until its own limit
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         hit       <= 1'b0;
         waitCount <= 4'h0;
      end else if (accStart) begin
         hit       <= optionReg[`CS_OPT_EN_BIT] &
                      matchFn(baseReg, accAddr);               // [R5]
         waitCount <= 4'h0;
      end else if (accEnd) begin
         hit       <= 1'b0;
      end else if (hit &&
                   waitCount != optionReg[`CS_OPT_WAIT_MSB:
                                          `CS_OPT_WAIT_LSB]) begin
         waitCount <= waitCount + 4'h1;                        // [R12]
      end
   end

   // termination once the programmed wait count has elapsed
   assign termReq = hit && !accStart &&
                    waitCount == optionReg[`CS_OPT_WAIT_MSB:
                                           `CS_OPT_WAIT_LSB];  // [R12]

endmodule

// [rtl/cs_decode.v]
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
`include "cs_decode_defines.vh"

module cs_decode (
   input  wire                  core_clk,
   input  wire                  nrst,
   input  wire                  hsel,
   input  wire [31:0]           haddr,
   input  wire [1:0]            htrans,
   input  wire                  hwrite,
   input  wire [2:0]            hsize,
   input  wire [31:0]           hwdata,
   input  wire                  hready,
   output reg  [31:0]           hrdata,
   output reg                   hreadyout,
   output reg                   hresp,
   input  wire [23:0]           accAddr,
   input  wire                  accStart,
   input  wire                  sizeAckLowN,
   input  wire                  sizeAckHighN,
   input  wire                  busCtrlConfigStrap,
   input  wire                  bootWidthStrap,
   output reg  [`CS_COUNT-1:0]  chipSelectN,
   output reg                   cycleDone,
   output reg                   busCtrlGpio,
   output reg                   bootPort16
);

   reg  [15:0]          csBaseAddressReg [0:`CS_COUNT-1];
   reg  [15:0]          csOptionReg      [0:`CS_COUNT-1];
   reg                  accActive;
   reg  [1:0]           ackLowSync;
   reg  [1:0]           ackHighSync;
   reg  [1:0]           cfgStrapSync;
   reg  [1:0]           widthStrapSync;
   reg  [1:0]           strapCount;
   reg                  strapDone;
   reg                  wrPending;
   reg  [3:0]           wrIdx;
   reg                  wrSel;
   wire [`CS_COUNT-1:0] hitVec;
   wire [`CS_COUNT-1:0] termVec;
   wire                 startOk;
   wire                 ackSeen;
   wire                 accEnd;
   wire                 addrPhase;
   wire [3:0]           rdIdx;
   wire [2:0]           rdKind;
   wire [2:0]           wrKind;
   integer              i;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // two flops on each acknowledge and strap pin
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ackLowSync     <= 2'h3;
         ackHighSync    <= 2'h3;
         cfgStrapSync   <= 2'h3;
         widthStrapSync <= 2'h3;
      end else begin
         ackLowSync     <= {ackLowSync[0], sizeAckLowN};
         ackHighSync    <= {ackHighSync[0], sizeAckHighN};
         cfgStrapSync   <= {cfgStrapSync[0], busCtrlConfigStrap};
         widthStrapSync <= {widthStrapSync[0], bootWidthStrap};
      end
   end

   // ----------------------------------------------------------------
   // strap capture after reset release
   // ----------------------------------------------------------------
   // straps taken once the synchronisers hold post-reset samples
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         strapCount <= 2'h0;
         strapDone  <= 1'b0;
         bootPort16 <= 1'b0;
      end else if (!strapDone) begin
         if (strapCount == `STRAP_DELAY) begin
            strapDone  <= 1'b1;
            bootPort16 <= widthStrapSync[1];                   // [R10]
         end else begin
            strapCount <= strapCount + 2'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // bus access cycle
   // ----------------------------------------------------------------
   assign startOk = accStart && !accActive;
   // a held-low acknowledge ends the cycle unless pins are I/O
   assign ackSeen = !busCtrlGpio &&
                    (!ackLowSync[1] || !ackHighSync[1]);      // [R8] [R9]
   // first termination from any source wins
   assign accEnd  = accActive && ((|termVec) || ackSeen);     // [R6]

   genvar g;
   generate
      for (g = 0; g < `CS_COUNT; g = g + 1) begin : gen_cs
         cs_unit i_cs_unit (
            .core_clk  (core_clk),
            .nrst      (nrst),
            .baseReg   (csBaseAddressReg[g]),
            .optionReg (csOptionReg[g]),
            .accAddr   (accAddr),
            .accStart  (startOk),
            .accEnd    (accEnd),
            .hit       (hitVec[g]),
            .termReq   (termVec[g])
         );
      end
   endgenerate

   // cycle state and registered chip-select pins
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         accActive   <= 1'b0;
         cycleDone   <= 1'b0;
         chipSelectN <= {`CS_COUNT{1'b1}};
      end else begin
         cycleDone <= accEnd;
         if (startOk)
            accActive <= 1'b1;
         else if (accEnd)
            accActive <= 1'b0;
         if (accActive && !accEnd)
            chipSelectN <= ~hitVec;                            // [R5]
         else
            chipSelectN <= {`CS_COUNT{1'b1}};
      end
   end

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   // kinds of register word, shared by the read and write paths
   localparam [2:0] KIND_NONE   = 3'h0;
   localparam [2:0] KIND_BASE   = 3'h1;
   localparam [2:0] KIND_OPTION = 3'h2;
   localparam [2:0] KIND_CONFIG = 3'h3;
   localparam [2:0] KIND_HITS   = 3'h4;

   // classify a word by its index and word select bit
   function [2:0] regKind;
      input [3:0] idx;
      input       sel;
      begin
         if (idx < `CS_COUNT && !sel)
            regKind = KIND_BASE;
         else if (idx < `CS_COUNT)
            regKind = KIND_OPTION;
         else if (idx == `REG_CFG_IDX && !sel)
            regKind = KIND_CONFIG;
         else if (idx == `REG_CFG_IDX)
            regKind = KIND_HITS;
         else
            regKind = KIND_NONE;
      end
   endfunction

   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------
   assign addrPhase = hsel && hready && htrans[1];
   assign rdIdx     = haddr[`REG_IDX_MSB:`REG_IDX_LSB];
   // read side decodes the live address, write side the captured one
   assign rdKind    = regKind(rdIdx, haddr[`REG_SEL_BIT]);
   assign wrKind    = regKind(wrIdx, wrSel);

   // zero-wait slave: read data registered in the address phase
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
         hrdata    <= 32'h00000000;
         wrPending <= 1'b0;
         wrIdx     <= 4'h0;
         wrSel     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wrPending <= addrPhase && hwrite;
         if (addrPhase) begin
            wrIdx <= rdIdx;
            wrSel <= haddr[`REG_SEL_BIT];
         end
         if (addrPhase && !hwrite) begin
            case (rdKind)
               KIND_BASE:   hrdata <= {16'h0000, csBaseAddressReg[rdIdx]};
               KIND_OPTION: hrdata <= {16'h0000, csOptionReg[rdIdx]};
               KIND_CONFIG: hrdata <= {29'h00000000, accActive, bootPort16,
                                       busCtrlGpio};
               KIND_HITS:   hrdata <= {20'h00000, hitVec};
               default:     hrdata <= 32'h00000000;
            endcase
         end
      end
   end

   // register file writes, pin assignment bit seeded by strap
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         busCtrlGpio <= 1'b0;
         for (i = 0; i < `CS_COUNT; i = i + 1) begin
            csBaseAddressReg[i] <= (i == 0) ? `CS_BOOT_BASE_RST
                                            : `CS_BASE_RST;
            csOptionReg[i]      <= (i == 0) ? `CS_BOOT_OPT_RST
                                            : `CS_OPT_RST;
         end
      end else begin
         if (!strapDone && strapCount == `STRAP_DELAY)
            busCtrlGpio <= !cfgStrapSync[1];                   // [R9]
         else if (wrPending && wrKind == KIND_CONFIG)
            busCtrlGpio <= hwdata[`CFG_GPIO_BIT];              // [R9]
         if (wrPending && wrKind == KIND_BASE)
            csBaseAddressReg[wrIdx] <= hwdata[15:0];           // [R1]
         if (wrPending && wrKind == KIND_OPTION)
            csOptionReg[wrIdx] <= hwdata[15:0];
      end
   end

endmodule

// [verification/cs_decode_props.sv]
`timescale 1ns/1ns
`include "cs_decode_defines.vh"
// ---------------------------
// access, strap and bus response checks
// ---------------------------
module cs_decode_props (
   input wire                 core_clk,
   input wire                 nrst,
   input wire                 accStart,
   input wire                 busCtrlConfigStrap,
   input wire                 bootWidthStrap,
   input wire [`CS_COUNT-1:0] chipSelectN,
   input wire                 cycleDone,
   input wire                 busCtrlGpio,
   input wire                 bootPort16,
   input wire                 hreadyout,
   input wire                 hresp
);
   reg       busyQ;
   reg [2:0] rstCnt;
   wire      act = busyQ & ~cycleDone;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // access tracker and edges since reset
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         busyQ  <= 1'b0;
         rstCnt <= 3'h0;
      end else begin
         busyQ  <= act | accStart;
         rstCnt <= rstCnt + {2'h0, rstCnt != 3'h7};
      end
   end
   done_pulse_a: assert property (cycleDone |=> !cycleDone)
      else $error("done longer than one cycle");
   done_cs_high_a: assert property (cycleDone |-> &chipSelectN)
      else $error("select low in end cycle");
   cs_idle_a: assert property (!act |-> &chipSelectN)
      else $error("select low outside access");
   done_act_a: assert property (cycleDone |-> $past(act))
      else $error("done without access");
   cs_fall_a: assert property
      (|(~chipSelectN & $past(chipSelectN)) |-> $past(act))
      else $error("select fell while idle");
   cs_rise_a: assert property
      (|(chipSelectN & ~$past(chipSelectN)) |-> cycleDone)
      else $error("select rose before end");
   strap_pre_a: assert property
      (rstCnt < 3'h3 |-> !busCtrlGpio && !bootPort16)
      else $error("strap result too early");
   strap_take_a: assert property (rstCnt == 3'h3 |->
      busCtrlGpio == !busCtrlConfigStrap && bootPort16 == bootWidthStrap)
      else $error("strap capture wrong");
   width_hold_a: assert property
      (rstCnt == 3'h7 |=> $stable(bootPort16))
      else $error("boot width changed");
   bus_okay_a: assert property
      (rstCnt != 3'h0 |-> hreadyout && !hresp)
      else $error("bus not ready or error");
endmodule

bind cs_decode cs_decode_props i_cs_decode_props (.core_clk(core_clk),
   .nrst(nrst), .accStart(accStart), .busCtrlConfigStrap(busCtrlConfigStrap),
   .bootWidthStrap(bootWidthStrap), .chipSelectN(chipSelectN),
   .cycleDone(cycleDone), .busCtrlGpio(busCtrlGpio),
   .bootPort16(bootPort16), .hreadyout(hreadyout), .hresp(hresp));

// [verification/ext_bus_model.sv]
`timescale 1ns/1ns
// ---------------------------
// external devices and straps
// ---------------------------
module ext_bus_model (
   input  wire        core_clk,
   input  wire [11:0] chipSelectN,
   input  wire        strapCtrl,
   input  wire        strapWidth,
   input  wire        ackForce,
   input  wire [3:0]  ackWait,
   output wire        sizeAckLowN,
   output wire        sizeAckHighN,
   output wire        busCtrlConfigStrap,
   output wire        bootWidthStrap
);
   reg [3:0] cnt = 4'h0;
   wire      ack = ackForce | (|ackWait & cnt >= ackWait);
   // cycles since a select went low
   always @(posedge core_clk) begin
      cnt <= &chipSelectN ? 4'h0 : cnt + {3'h0, cnt != 4'hF};
   end
   // acks pulled up when idle while ackForce is low
   assign sizeAckLowN        = ~ack;
   assign sizeAckHighN       = ~ack;
   assign busCtrlConfigStrap = strapCtrl;
   assign bootWidthStrap     = strapWidth;
endmodule

// [verification/chip_select_address_decode_bench.sv]
`timescale 1ns/1ns
module chip_select_address_decode_bench;
   reg          core_clk = 1'b0, nrst = 1'b0, hsel = 1'b1, hwrite = 1'b0;
   reg          accStart = 1'b0, strapCtrl = 1'b1, strapWidth = 1'b1;
   reg          ackForce = 1'b0;
   reg  [1:0]   htrans = 2'h0;
   reg  [3:0]   ackWait = 4'h0;
   reg  [23:0]  accAddr = 24'h0;
   reg  [31:0]  haddr = 32'h0, hwdata = 32'h0, rd;
   wire [31:0]  hrdata;
   wire [11:0]  chipSelectN;
   wire         hreadyout, hresp, cycleDone, busCtrlGpio, bootPort16;
   wire         sizeAckLowN, sizeAckHighN, busCtrlConfigStrap, bootWidthStrap;
   integer      miscompares = 0, comparisons = 0, k, n;
   integer      sh [0:7] = '{11, 13, 14, 16, 17, 18, 19, 20};
   cs_decode i_cs_decode (.core_clk(core_clk), .nrst(nrst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .accAddr(accAddr),
      .accStart(accStart), .sizeAckLowN(sizeAckLowN),
      .sizeAckHighN(sizeAckHighN), .busCtrlConfigStrap(busCtrlConfigStrap),
      .bootWidthStrap(bootWidthStrap), .chipSelectN(chipSelectN),
      .cycleDone(cycleDone), .busCtrlGpio(busCtrlGpio),
      .bootPort16(bootPort16));
   ext_bus_model i_ext_bus_model (.core_clk(core_clk),
      .chipSelectN(chipSelectN), .strapCtrl(strapCtrl),
      .strapWidth(strapWidth), .ackForce(ackForce), .ackWait(ackWait),
      .sizeAckLowN(sizeAckLowN), .sizeAckHighN(sizeAckHighN),
      .busCtrlConfigStrap(busCtrlConfigStrap),
      .bootWidthStrap(bootWidthStrap));
   // 125 MHz clock
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   task check(input logic [31:0] got, input logic [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            miscompares = miscompares + 1;
         end
      end
   endtask
   task waitReady;
      begin
         @(posedge core_clk);
         while (hreadyout !== 1'b1) @(posedge core_clk);
      end
   endtask
   // one single word transfer, address then data phase
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      begin
         htrans <= 2'h2;
         haddr  <= a;
         hwrite <= w;
         waitReady();
         htrans <= 2'h0;
         hwdata <= d;
         waitReady();
         rd = hrdata;
      end
   endtask
   task rdc(input logic [31:0] a, input logic [31:0] e);
      begin
         ahb(1'b0, a, 32'h0);
         check(rd, e);
      end
   endtask
   // one access: selects seen low and edges until done
   task acc(input logic [23:0] a, input logic [11:0] cs);
      logic [11:0] seen;
      begin
         accAddr  <= a;
         accStart <= 1'b1;
         @(posedge core_clk);
         accStart <= 1'b0;
         seen = 12'h000;
         n = 0;
         while (cycleDone !== 1'b1) begin
            @(posedge core_clk);
            seen = seen | ~chipSelectN;
            n = n + 1;
         end
         check(seen, cs);
      end
   endtask
   task final_report;
      begin
         $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
         if (miscompares == 0 && comparisons > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // watchdog
   initial begin
      repeat (6000) @(posedge core_clk);
      miscompares = miscompares + 1;
      final_report();
   end
   // main sequence
   initial begin
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (5) @(posedge core_clk);
      check({busCtrlGpio, bootPort16}, 2'h1);
      rdc(32'h0, 32'h0007);
      rdc(32'h4, 32'h800F);
      rdc(32'h8, 32'h0);
      rdc(32'h60, 32'h2);
      rdc(32'h70, 32'h0);
      acc(24'h0FFFFF, 12'h001);
      check(n, 17);
      ahb(1'b1, 32'h4, 32'h0);
      ahb(1'b1, 32'hC, 32'h8002);
      for (k = 0; k < 8; k = k + 1) begin
         ahb(1'b1, 32'h8, 32'h8000 | k);
         acc(24'h800000 + (24'h1 << sh[k]) - 24'h1, 12'h002);
         check(n, 4);
         ackForce <= 1'b1;
         acc(24'h800000 + (24'h1 << sh[k]), 12'h000);
         ackForce <= 1'b0;
         repeat (3) @(posedge core_clk);
      end
      ahb(1'b1, 32'h8, 32'h0504);
      ahb(1'b1, 32'hC, 32'h8003);
      ahb(1'b1, 32'h58, 32'h0400);
      ahb(1'b1, 32'h5C, 32'h800C);
      acc(24'h040000, 12'h802);
      check(n, 5);
      ahb(1'b1, 32'h58, 32'h0300);
      ahb(1'b1, 32'hC, 32'h800F);
      ackWait <= 4'h1;
      acc(24'h040000, 12'h002);
      check(n, 6);
      ackWait <= 4'h0;
      ahb(1'b1, 32'h60, 32'h1);
      rdc(32'h60, 32'h3);
      nrst       <= 1'b0;
      strapCtrl  <= 1'b0;
      strapWidth <= 1'b0;
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (5) @(posedge core_clk);
      check({busCtrlGpio, bootPort16}, 2'h2);
      rdc(32'h60, 32'h1);
      // hit vector and active flag seen in the middle of a boot access
      accStart <= 1'b1;
      @(posedge core_clk);
      accStart <= 1'b0;
      rdc(32'h64, 32'h001);
      rdc(32'h60, 32'h5);
      while (cycleDone !== 1'b1) @(posedge core_clk);
      ackForce <= 1'b1;
      acc(24'h000000, 12'h001);
      check(n, 17);
      final_report();
   end
endmodule
